// ===== logic/tds_pkg.sv
// Package with constants and carrier types of the ride-through supervisor.
package tds_pkg;

  // Clock rate and derived timing.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned STORE_PERIOD_S = 3600;
  localparam longint unsigned STORE_PERIOD_CYC = STORE_PERIOD_S * CLK_HZ;

  // Frequency words are in hertz.
  localparam int FREQ_W = 16;
  localparam logic [15:0] MIN_VIB_HZ = 16'h0064;
  // Retune window is thirty percent, kept as a fraction of 100.
  localparam int unsigned WINDOW_PCT = 30;
  localparam int unsigned PCT_FULL = 100;

  // Bus voltage words are in volts.
  localparam int VOLT_W = 12;
  localparam logic [11:0] UNDERVOLT_V = 12'h09e;

  // Detection time is counted in milliseconds.
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int TIME_W = 16;

  // Reset value of the notch settings and interrupt status bit positions.
  localparam logic [15:0] NOTCH_RST = 16'h1194;
  localparam int IRQ_W = 4;
  localparam int IRQ_RETUNE = 0;
  localparam int IRQ_STORE = 1;
  localparam int IRQ_RIDE = 2;
  localparam int IRQ_UV = 3;

  // Avalon register offsets, byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NOTCH1 = 8'h04;
  localparam logic [7:0] REG_NOTCH2 = 8'h08;
  localparam logic [7:0] REG_NOTCH3 = 8'h0c;
  localparam logic [7:0] REG_NOTCH4 = 8'h10;
  localparam logic [7:0] REG_NOTCH5 = 8'h14;
  localparam logic [7:0] REG_OSC_LVL = 8'h18;
  localparam logic [7:0] REG_PF_TIME = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_IRQ_STAT = 8'h24;
  localparam logic [7:0] REG_IRQ_MASK = 8'h28;
  localparam logic [31:0] UNMAPPED_RD = 32'hdead_0bad;

  // Control register fields.
  localparam int CTRL_EN = 0;
  localparam int CTRL_TLIM = 1;
  localparam int CTRL_W = 2;
  localparam logic [15:0] OSC_LVL_RST = 16'h0032;
  localparam logic [15:0] PF_TIME_RST = 16'h000a;

  // Ride-through state, Gray coded along the usual path.
  typedef enum logic [1:0] {
    TDS_IDLE = 2'b00,
    TDS_RIDE = 2'b01,
    TDS_ALARM = 2'b11
  } tds_state_t;

  // Resonance detector report.
  typedef struct packed {
    logic valid;
    logic [15:0] freq;
    logic [15:0] amp;
  } tds_reso_t;

  // Status outputs toward the host controller and power stage.
  typedef struct packed {
    logic ride_through;
    logic brake_interlock;
    logic malfunction;
    logic warning;
    logic base_drive;
    logic torque_limit;
    logic supply_drop_alarm;
    logic bus_drop_alarm;
  } tds_out_t;

endpackage

// ===== logic/tds_supervisor.sv
// Ride-through supervisor: notch retuning and power failure ride-through.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: A control bit enables or disables both retuning and ride-through.
// R2: Retuning acts only within thirty percent of notch one or notch two.
// R3: Only the notch setting closer to the measured resonance is rewritten.
// R4: Retuning is continuous but storage commits at most once per hour.
// R5: Notch settings three, four and five are never touched by retuning.
// R6: Resonances at or below 100 Hz are ignored.
// R7: Detection sensitivity comes from the oscillation detect level setting.
// R8: The supply drop alarm fires only when failure outlasts the set time; with the enable bit clear the code raises it at once on supply loss.
// R9: During ride-through the bus drop threshold is adjusted automatically.
// R10: The during-ride-through output rises once a supply failure is seen.
// R11: The brake interlock stays asserted throughout ride-through.
// R12: The brake interlock drops when an undervoltage alarm is raised.
// R13: Bus voltage below 158 V raises undervoltage at once, in any mode.
// R14: A short failure with bus voltage held ends with no alarm.
// R15: With torque limiting selected, torque is limited during failure.
// R16: Heavy load may raise the bus drop alarm before the set time.
// R17: Undervoltage asserts malfunction and switches off base drive.
//////////////////////////////////////////////////////////////////////////////
module tds_supervisor #(
  parameter longint unsigned STORE_CYC = tds_pkg::STORE_PERIOD_CYC,
  parameter int unsigned MS_CYCLES = tds_pkg::MS_CYC,
  parameter logic [11:0] RIDE_BUS_V = 12'h0c8,
  parameter logic [11:0] HEAVY_MARGIN_V = 12'h014
) (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Drive sensing.
  input wire tds_pkg::tds_reso_t reso_i,
  input wire logic supply_ok_i,
  input wire logic [11:0] bus_volt_i,
  input wire logic heavy_load_i,
  input wire logic brake_req_i,
  // Storage commit handshake.
  output logic store_req_o,
  output logic [15:0] store_n1_o,
  output logic [15:0] store_n2_o,
  // Status outputs and interrupt.
  output tds_pkg::tds_out_t out_o,
  output logic irq_o
);

  initial begin
    if (MS_CYCLES < 1 || STORE_CYC < 2) begin
      $error("tds_supervisor: bad timing parameters");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State record.
  typedef struct packed {
    logic [31:0] rdata;
    logic wait_n;
    logic [tds_pkg::CTRL_W-1:0] ctrl;
    logic [15:0] n1;
    logic [15:0] n2;
    logic [15:0] n3;
    logic [15:0] n4;
    logic [15:0] n5;
    logic [15:0] osc_lvl;
    logic [15:0] pf_time;
    logic [tds_pkg::IRQ_W-1:0] ist;
    logic [tds_pkg::IRQ_W-1:0] imsk;
    logic irq;
    tds_pkg::tds_state_t st;
    logic [31:0] ms_cnt;
    logic [15:0] fail_ms;
    logic [63:0] store_cnt;
    logic dirty;
    logic store_req;
    logic [15:0] s1;
    logic [15:0] s2;
    tds_pkg::tds_out_t out;
  } tds_reg_t;

  tds_reg_t r_q;
  tds_reg_t r_d;

  // Retune window helpers; widened so products cannot overflow.
  logic [31:0] f100;
  logic [31:0] lo1;
  logic [31:0] hi1;
  logic [31:0] lo2;
  logic [31:0] hi2;
  logic in1;
  logic in2;
  logic [15:0] d1;
  logic [15:0] d2;
  logic detect;
  logic acc;
  logic wr_hit;
  logic [31:0] rd_mux;
  logic uv_now;
  logic [11:0] bus_thr;
  logic [tds_pkg::IRQ_W-1:0] ev;

  assign f100 = 32'(reso_i.freq) * 32'(tds_pkg::PCT_FULL);
  assign lo1 = 32'(r_q.n1) * 32'(tds_pkg::PCT_FULL - tds_pkg::WINDOW_PCT);
  assign hi1 = 32'(r_q.n1) * 32'(tds_pkg::PCT_FULL + tds_pkg::WINDOW_PCT);
  assign lo2 = 32'(r_q.n2) * 32'(tds_pkg::PCT_FULL - tds_pkg::WINDOW_PCT);
  assign hi2 = 32'(r_q.n2) * 32'(tds_pkg::PCT_FULL + tds_pkg::WINDOW_PCT);
  // R2 window check.
  assign in1 = (f100 >= lo1) && (f100 <= hi1);
  assign in2 = (f100 >= lo2) && (f100 <= hi2);
  assign d1 = (reso_i.freq > r_q.n1) ? reso_i.freq - r_q.n1
                                     : r_q.n1 - reso_i.freq;
  assign d2 = (reso_i.freq > r_q.n2) ? reso_i.freq - r_q.n2
                                     : r_q.n2 - reso_i.freq;
  // R6 low band ignored, R7 sensitivity level, R1 master enable.
  assign detect = reso_i.valid && r_q.ctrl[tds_pkg::CTRL_EN] &&
                  (reso_i.freq > tds_pkg::MIN_VIB_HZ) &&
                  (reso_i.amp >= r_q.osc_lvl);

  // R9 adjusted bus threshold while riding through.
  assign bus_thr = (r_q.st == tds_pkg::TDS_RIDE) ?
                   (heavy_load_i ? RIDE_BUS_V + HEAVY_MARGIN_V : RIDE_BUS_V) :
                   tds_pkg::UNDERVOLT_V;
  // R13 hard undervoltage level, independent of mode.
  assign uv_now = bus_volt_i < tds_pkg::UNDERVOLT_V;

  assign acc = (avs_read_i || avs_write_i) && !r_q.wait_n;
  // A write lands only at the edge where waitrequest is seen low.
  assign wr_hit = avs_write_i && r_q.wait_n;

  //////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.
  always_comb begin
    case (avs_address_i)
      tds_pkg::REG_CTRL: rd_mux = 32'(r_q.ctrl);
      tds_pkg::REG_NOTCH1: rd_mux = 32'(r_q.n1);
      tds_pkg::REG_NOTCH2: rd_mux = 32'(r_q.n2);
      tds_pkg::REG_NOTCH3: rd_mux = 32'(r_q.n3);
      tds_pkg::REG_NOTCH4: rd_mux = 32'(r_q.n4);
      tds_pkg::REG_NOTCH5: rd_mux = 32'(r_q.n5);
      tds_pkg::REG_OSC_LVL: rd_mux = 32'(r_q.osc_lvl);
      tds_pkg::REG_PF_TIME: rd_mux = 32'(r_q.pf_time);
      tds_pkg::REG_STATUS: rd_mux = {22'h0, r_q.st, r_q.out};
      tds_pkg::REG_IRQ_STAT: rd_mux = 32'(r_q.ist);
      tds_pkg::REG_IRQ_MASK: rd_mux = 32'(r_q.imsk);
      default: rd_mux = tds_pkg::UNMAPPED_RD;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state. Writes take effect when waitrequest is low, one cycle after
  // the request is first seen; this costs a cycle but keeps reads registered.
  always_comb begin
    r_d = r_q;
    ev = '0;
    r_d.wait_n = acc;
    r_d.store_req = 1'b0;
    if (acc && avs_read_i) begin
      r_d.rdata = rd_mux;
    end
    if (wr_hit && avs_byteenable_i[0]) begin
      case (avs_address_i)
        tds_pkg::REG_CTRL: r_d.ctrl = avs_writedata_i[tds_pkg::CTRL_W-1:0];
        tds_pkg::REG_NOTCH1: r_d.n1 = avs_writedata_i[15:0];
        tds_pkg::REG_NOTCH2: r_d.n2 = avs_writedata_i[15:0];
        tds_pkg::REG_NOTCH3: r_d.n3 = avs_writedata_i[15:0];
        tds_pkg::REG_NOTCH4: r_d.n4 = avs_writedata_i[15:0];
        tds_pkg::REG_NOTCH5: r_d.n5 = avs_writedata_i[15:0];
        tds_pkg::REG_OSC_LVL: r_d.osc_lvl = avs_writedata_i[15:0];
        tds_pkg::REG_PF_TIME: r_d.pf_time = avs_writedata_i[15:0];
        tds_pkg::REG_IRQ_STAT:
          r_d.ist = r_q.ist & ~avs_writedata_i[tds_pkg::IRQ_W-1:0];
        tds_pkg::REG_IRQ_MASK: r_d.imsk = avs_writedata_i[tds_pkg::IRQ_W-1:0];
        default: r_d.ctrl = r_q.ctrl;
      endcase
    end

    // R3 closer setting wins; R5 notches three to five untouched.
    if (detect && (in1 || in2)) begin
      ev[tds_pkg::IRQ_RETUNE] = 1'b1;
      r_d.dirty = 1'b1;
      if (in1 && (!in2 || d1 <= d2)) begin
        r_d.n1 = reso_i.freq;
      end else begin
        r_d.n2 = reso_i.freq;
      end
    end

    // R4 hourly commit of retuned values.
    if (r_q.store_cnt != 64'h0) begin
      r_d.store_cnt = r_q.store_cnt - 64'h1;
    end else if (r_q.dirty) begin
      r_d.store_req = 1'b1;
      r_d.s1 = r_q.n1;
      r_d.s2 = r_q.n2;
      r_d.dirty = 1'b0;
      r_d.store_cnt = STORE_CYC - 64'h1;
      ev[tds_pkg::IRQ_STORE] = 1'b1;
    end

    // Ride-through machine.
    r_d.out.warning = 1'b0;
    case (r_q.st)
      tds_pkg::TDS_IDLE: begin
        r_d.ms_cnt = 32'h0;
        r_d.fail_ms = 16'h0;
        if (!supply_ok_i && r_q.ctrl[tds_pkg::CTRL_EN]) begin
          // R10 during-ride-through on detection.
          r_d.st = tds_pkg::TDS_RIDE;
          r_d.out.ride_through = 1'b1;
          ev[tds_pkg::IRQ_RIDE] = 1'b1;
        end else if (!supply_ok_i) begin
          // Without ride-through a supply loss is an immediate drop alarm.
          r_d.st = tds_pkg::TDS_ALARM;
          r_d.out.supply_drop_alarm = 1'b1;
        end
      end
      tds_pkg::TDS_RIDE: begin
        // R15 torque limit while riding through.
        r_d.out.torque_limit = r_q.ctrl[tds_pkg::CTRL_TLIM];
        r_d.out.warning = 1'b1;
        if (r_q.ms_cnt >= MS_CYCLES - 1) begin
          r_d.ms_cnt = 32'h0;
          r_d.fail_ms = r_q.fail_ms + 16'h1;
        end else begin
          r_d.ms_cnt = r_q.ms_cnt + 32'h1;
        end
        if (supply_ok_i) begin
          // R14 short failure recovers silently.
          r_d.st = tds_pkg::TDS_IDLE;
          r_d.out.ride_through = 1'b0;
          r_d.out.torque_limit = 1'b0;
        end else if (r_q.fail_ms >= r_q.pf_time) begin
          // R8 failure outlasted the detection time.
          r_d.st = tds_pkg::TDS_ALARM;
          r_d.out.supply_drop_alarm = 1'b1;
        end else if (bus_volt_i < bus_thr) begin
          // R16 heavy load bus drop before the time.
          r_d.st = tds_pkg::TDS_ALARM;
          r_d.out.bus_drop_alarm = 1'b1;
        end
      end
      tds_pkg::TDS_ALARM: begin
        r_d.out.ride_through = 1'b0;
        r_d.out.torque_limit = 1'b0;
      end
      default: r_d.st = tds_pkg::TDS_IDLE;
    endcase

    // R13 immediate undervoltage in any state.
    if (uv_now) begin
      r_d.st = tds_pkg::TDS_ALARM;
      r_d.out.bus_drop_alarm = 1'b1;
      r_d.out.ride_through = 1'b0;
      r_d.out.torque_limit = 1'b0;
    end
    if (r_d.st == tds_pkg::TDS_ALARM && r_q.st != tds_pkg::TDS_ALARM) begin
      ev[tds_pkg::IRQ_UV] = 1'b1;
    end
    // R17 malfunction and base drive follow the alarm state.
    r_d.out.malfunction = (r_d.st == tds_pkg::TDS_ALARM);
    r_d.out.base_drive = (r_d.st != tds_pkg::TDS_ALARM);
    // R11 held in ride-through, R12 dropped on alarm.
    r_d.out.brake_interlock = (r_d.st == tds_pkg::TDS_RIDE) ||
                              (brake_req_i && r_d.st != tds_pkg::TDS_ALARM);

    // Sticky status: a set in the clearing cycle survives.
    r_d.ist = r_d.ist | ev;
    r_d.irq = |(r_d.ist & r_d.imsk);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r_q <= '0;
      r_q.n1 <= tds_pkg::NOTCH_RST;
      r_q.n2 <= tds_pkg::NOTCH_RST;
      r_q.n3 <= tds_pkg::NOTCH_RST;
      r_q.n4 <= tds_pkg::NOTCH_RST;
      r_q.n5 <= tds_pkg::NOTCH_RST;
      r_q.osc_lvl <= tds_pkg::OSC_LVL_RST;
      r_q.pf_time <= tds_pkg::PF_TIME_RST;
      r_q.st <= tds_pkg::TDS_IDLE;
      r_q.out.base_drive <= 1'b1;
    end else if (ce_i) begin
      r_q <= r_d;
    end
  end

  assign avs_readdata_o = r_q.rdata;
  assign avs_waitrequest_o = !r_q.wait_n;
  assign store_req_o = r_q.store_req;
  assign store_n1_o = r_q.s1;
  assign store_n2_o = r_q.s2;
  assign out_o = r_q.out;
  assign irq_o = r_q.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_ride_entry;
    r_q.st == tds_pkg::TDS_IDLE && !supply_ok_i && !uv_now &&
    r_q.ctrl[tds_pkg::CTRL_EN] && ce_i;
  endsequence

  property p_ride_out;
    @(posedge clk_sys_i) disable iff (srst_i)
    s_ride_entry |=> out_o.ride_through;
  endproperty
  a_ride_out: assert property (p_ride_out) // R10
    else $error("ride-through output missing");

  property p_brake_ride;
    @(posedge clk_sys_i) disable iff (srst_i)
    r_q.st == tds_pkg::TDS_RIDE |-> out_o.brake_interlock;
  endproperty
  a_brake_ride: assert property (p_brake_ride) // R11
    else $error("brake dropped during ride-through");

  property p_brake_alarm;
    @(posedge clk_sys_i) disable iff (srst_i)
    out_o.malfunction |-> !out_o.brake_interlock && !out_o.base_drive;
  endproperty
  a_brake_alarm: assert property (p_brake_alarm) // R12
    else $error("brake or base drive on under alarm");

  property p_uv_now;
    @(posedge clk_sys_i) disable iff (srst_i)
    uv_now && ce_i |=> out_o.malfunction;
  endproperty
  a_uv_now: assert property (p_uv_now) // R13
    else $error("undervoltage not raised at once");

  property p_n345;
    @(posedge clk_sys_i) disable iff (srst_i)
    !(avs_write_i && !avs_waitrequest_o) |=> $stable(r_q.n3) &&
    $stable(r_q.n4) && $stable(r_q.n5);
  endproperty
  a_n345: assert property (p_n345) // R5
    else $error("notch three to five changed");

  property p_low_band;
    @(posedge clk_sys_i) disable iff (srst_i)
    reso_i.valid && reso_i.freq <= tds_pkg::MIN_VIB_HZ && !avs_write_i
    |=> $stable(r_q.n1) && $stable(r_q.n2);
  endproperty
  a_low_band: assert property (p_low_band) // R6
    else $error("low band resonance retuned");

  property p_store_gap;
    @(posedge clk_sys_i) disable iff (srst_i)
    store_req_o |=> !store_req_o [*8];
  endproperty
  a_store_gap: assert property (p_store_gap) // R4
    else $error("storage commits too close");

  property p_disabled;
    @(posedge clk_sys_i) disable iff (srst_i)
    !r_q.ctrl[tds_pkg::CTRL_EN] && !avs_write_i && ce_i
    |=> $stable(r_q.n1) && !out_o.ride_through;
  endproperty
  a_disabled: assert property (p_disabled) // R1
    else $error("supervisor active while disabled");

endmodule
`default_nettype wire

// ===== verification/tds_power_stage.sv
// Behavioural model of the power stage, mains feed and commit counter.
`timescale 1ns/10ps
`default_nettype none
module tds_power_stage #(
  parameter logic [11:0] NOMINAL_V = 12'h118
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Scenario controls.
  input wire logic mains_on_i,
  input wire logic [11:0] target_v_i,
  // Drive side.
  input wire logic store_req_i,
  output logic supply_ok_o,
  output logic [11:0] bus_volt_o,
  output logic [7:0] store_cnt_o
);
  logic [11:0] aim;

  // Without mains the capacitor drains towards zero.
  assign aim = mains_on_i ? target_v_i : 12'h000;

  //////////////////////////////////////////////////////////////////////////
  // The bus slews one volt per cycle, since a charged bus never jumps.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bus_volt_o <= NOMINAL_V;
      store_cnt_o <= 8'h00;
      supply_ok_o <= 1'b1;
    end else begin
      supply_ok_o <= mains_on_i;
      if (bus_volt_o > aim) begin
        bus_volt_o <= bus_volt_o - 12'h001;
      end else if (bus_volt_o < aim) begin
        bus_volt_o <= bus_volt_o + 12'h001;
      end
      if (store_req_i) begin
        store_cnt_o <= store_cnt_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tds_supervisor_tb.sv
// Self-checking testbench of the ride-through supervisor.
`timescale 1ns/10ps
`default_nettype none
module tds_supervisor_tb;
  logic clk, srst, rd_en, wr_en, wait_req, supply_ok, store_req, irq;
  logic mains_on;
  logic heavy, brake_req;
  logic [15:0] store_n1, store_n2;
  logic [7:0] addr;
  logic [7:0] store_cnt;
  logic [7:0] c0;
  logic [11:0] bus_v;
  logic [11:0] target_v;
  logic [31:0] wdata, rdata, rv;
  tds_pkg::tds_reso_t reso;
  tds_pkg::tds_out_t outs;
  int n_mismatch;
  int tests_run;

  tds_supervisor #(.STORE_CYC(20), .MS_CYCLES(4)) tds_supervisor_inst (
    .clk_sys_i(clk), .srst_i(srst), .ce_i(1'b1),
    .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .reso_i(reso), .supply_ok_i(supply_ok), .bus_volt_i(bus_v),
    .heavy_load_i(heavy), .brake_req_i(brake_req), .store_req_o(store_req),
    .store_n1_o(store_n1), .store_n2_o(store_n2), .out_o(outs),
    .irq_o(irq));

  tds_power_stage tds_power_stage_inst (
    .clk_sys_i(clk), .srst_i(srst), .mains_on_i(mains_on),
    .target_v_i(target_v), .store_req_i(store_req),
    .supply_ok_o(supply_ok), .bus_volt_o(bus_v), .store_cnt_o(store_cnt));

  //////////////////////////////////////////////////////////////////////////
  // Clock and time-zero values.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reports one comparison; unknowns never count as a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr_en <= wr;
    rd_en <= ~wr;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) n_mismatch++;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, rv);
    chk(rv, e);
  endtask

  task automatic pulse(input logic [15:0] f, input logic [15:0] a);
    @(posedge clk);
    reso <= '{valid: 1'b1, freq: f, amp: a};
    @(posedge clk);
    reso.valid <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    mains_on <= 1'b1;
    target_v <= 12'h118;
    heavy <= 1'b0;
    brake_req <= 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Reset values, all five notch words and an unmapped read.
  task automatic t_reset_vals();
    chk(outs, 8'h08);
    chk(irq, 1'b0);
    for (int i = 1; i <= 5; i++) begin
      expect_reg(8'(i * 4), {16'h0000, tds_pkg::NOTCH_RST});
    end
    expect_reg(tds_pkg::REG_OSC_LVL, {16'h0000, tds_pkg::OSC_LVL_RST});
    expect_reg(tds_pkg::REG_PF_TIME, {16'h0000, tds_pkg::PF_TIME_RST});
    expect_reg(8'h3c, tds_pkg::UNMAPPED_RD);
  endtask

  // Retuning: window, notch three kept, level, low band, commits, disable.
  task automatic t_retune();
    wr(tds_pkg::REG_CTRL, 32'h0000_0001);
    wr(tds_pkg::REG_NOTCH1, 32'h0000_03e8);
    wr(tds_pkg::REG_NOTCH2, 32'h0000_07d0);
    wr(tds_pkg::REG_NOTCH3, 32'h0000_04b0);
    c0 = store_cnt;
    pulse(16'h04d8, 16'h0040);
    pulse(16'h04e2, 16'h0040);
    repeat (15) @(posedge clk);
    chk(32'(store_cnt - c0 > 8'h01), 32'h0);
    chk({store_n1, store_n2}, 32'h04d8_07d0);
    expect_reg(tds_pkg::REG_NOTCH1, 32'h0000_04e2);
    expect_reg(tds_pkg::REG_NOTCH3, 32'h0000_04b0);
    pulse(16'h0a8c, 16'h0040);
    expect_reg(tds_pkg::REG_NOTCH2, 32'h0000_07d0);
    pulse(16'h0708, 16'h0010);
    expect_reg(tds_pkg::REG_NOTCH2, 32'h0000_07d0);
    pulse(16'h0708, 16'h0040);
    expect_reg(tds_pkg::REG_NOTCH2, 32'h0000_0708);
    wr(tds_pkg::REG_NOTCH1, 32'h0000_0064);
    pulse(16'h0064, 16'h0040);
    expect_reg(tds_pkg::REG_NOTCH1, 32'h0000_0064);
    wr(tds_pkg::REG_CTRL, 32'h0000_0000);
    pulse(16'h06d6, 16'h0040);
    expect_reg(tds_pkg::REG_NOTCH2, 32'h0000_0708);
  endtask

  // Short failure rides through; also raises, masks and clears the irq.
  task automatic t_short_fail();
    do_reset();
    wr(tds_pkg::REG_CTRL, 32'h0000_0001);
    wr(tds_pkg::REG_PF_TIME, 32'h0000_0003);
    mains_on <= 1'b0;
    repeat (4) @(posedge clk);
    chk(outs.ride_through, 1'b1);
    chk(outs.brake_interlock, 1'b1);
    mains_on <= 1'b1;
    repeat (30) @(posedge clk);
    chk({outs.supply_drop_alarm, outs.malfunction}, 2'b00);
    chk(outs.base_drive, 1'b1);
    expect_reg(tds_pkg::REG_IRQ_STAT, 32'h0000_0004);
    chk(irq, 1'b0);
    wr(tds_pkg::REG_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(tds_pkg::REG_IRQ_STAT, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask

  // Long failure with torque limiting: alarm only after the set time.
  task automatic t_long_fail();
    int n;
    do_reset();
    wr(tds_pkg::REG_CTRL, 32'h0000_0003);
    wr(tds_pkg::REG_PF_TIME, 32'h0000_0003);
    brake_req <= 1'b1;
    mains_on <= 1'b0;
    // Torque limiting starts one cycle after the ride-through entry.
    repeat (4) @(posedge clk);
    chk(outs.torque_limit, 1'b1);
    repeat (5) @(posedge clk);
    chk(outs.supply_drop_alarm, 1'b0);
    chk(outs.brake_interlock, 1'b1);
    n = 0;
    while (outs.supply_drop_alarm !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk(outs.supply_drop_alarm, 1'b1);
    chk({outs.malfunction, outs.base_drive}, 2'b10);
    chk(outs.brake_interlock, 1'b0);
  endtask

  // Bus sag below the undervoltage level with ride-through disabled.
  task automatic t_undervolt();
    int n;
    do_reset();
    wr(tds_pkg::REG_CTRL, 32'h0000_0000);
    target_v <= 12'h09d;
    n = 0;
    while (bus_v >= tds_pkg::UNDERVOLT_V && n < 300) begin
      @(posedge clk);
      chk(outs.bus_drop_alarm, 1'b0);
      n++;
    end
    repeat (3) @(posedge clk);
    chk(outs.bus_drop_alarm, 1'b1);
    chk({outs.malfunction, outs.base_drive}, 2'b10);
  endtask

  // Heavy load trips the raised ride-through bus level before the set time.
  task automatic t_heavy();
    int n;
    do_reset();
    wr(tds_pkg::REG_CTRL, 32'h0000_0001);
    wr(tds_pkg::REG_PF_TIME, 32'h0000_0fff);
    heavy <= 1'b1;
    mains_on <= 1'b0;
    n = 0;
    while (outs.bus_drop_alarm !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({outs.bus_drop_alarm, outs.supply_drop_alarm}, 2'b10);
    chk(32'(bus_v >= tds_pkg::UNDERVOLT_V), 32'h1);
    chk({outs.malfunction, outs.base_drive}, 2'b10);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    srst = 1'b1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    reso = '0;
    mains_on = 1'b1;
    target_v = 12'h118;
    heavy = 1'b0;
    brake_req = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset_vals();
    t_retune();
    t_short_fail();
    t_long_fail();
    t_undervolt();
    t_heavy();
    conclude();
  end

  // Watchdog at 20000 cycles, far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
